/* File: hwpf_chan.v */
// One encoder decode/counter channel with its PFM pulse/direction output
// Assumes pin inputs are asynchronous; pfm_tick is a one-cycle enable on aclk
`timescale 1ns/10ps
`include "hwpf_map.vh"
module hwpf_chan (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        pin_a,
  input  wire        pin_b,
  input  wire        pin_c,
  input  wire [3:0]  decode_sel,
  input  wire [15:0] pfm_cmd,
  input  wire        c_is_pfm,
  input  wire        pfm_tick,
  input  wire [7:0]  pulse_width,
  input  wire        capture,
  output reg  [23:0] count_r,
  output reg  [23:0] cap_r,
  output reg         pul_r,
  output reg         dir_r
);
  reg  [2:0]  sa_r;
  reg  [2:0]  sb_r;
  reg  [2:0]  sc_r;
  reg  [23:0] timer_r;
  reg  [15:0] acc_r;
  reg  [7:0]  wcnt_r;
  reg  [14:0] ramp_r;
  reg         step;
  reg         up;
  reg  [2:0]  hi;
  reg  [2:0]  hp;
  wire        a  = sa_r[1];
  wire        b  = sb_r[1];
  wire        ea = sa_r[1] ^ sa_r[2];
  wire        eb = sb_r[1] ^ sb_r[2];
  wire        rev = decode_sel[`HWPF_DEC_REV];
  wire [15:0] mag = pfm_cmd[15] ? ((pfm_cmd == 16'h8000) ? `HWPF_CMD_FULL
                    : (~pfm_cmd + 16'h0001)) : pfm_cmd;
  wire [16:0] sum = {1'b0, acc_r} + {1'b0, mag};
  wire [16:0] rem = sum - `HWPF_PFM_MOD;
  wire        fire = pfm_tick & (sum >= `HWPF_PFM_MOD);
  wire        timer_mode = (decode_sel == `HWPF_DEC_TIMER);

  // Hall state order 1,3,2,6,4,5 mapped to 0..5, 7 = invalid
  function [2:0] hall_idx;
    input [2:0] s;
    begin
      case (s)
        3'h1: hall_idx = 3'h0;
        3'h3: hall_idx = 3'h1;
        3'h2: hall_idx = 3'h2;
        3'h6: hall_idx = 3'h3;
        3'h4: hall_idx = 3'h4;
        3'h5: hall_idx = 3'h5;
        default: hall_idx = 3'h7;
      endcase
    end
  endfunction

  always @*
  begin
    step = 1'b0;
    up   = 1'b0;
    hi   = hall_idx({sa_r[1], sb_r[1], sc_r[1]});
    hp   = hall_idx({sa_r[2], sb_r[2], sc_r[2]});
    if (!decode_sel[3])
    begin
      case (decode_sel[1:0])
        `HWPF_QD_PD, `HWPF_QD_X1:
        begin
          step = a & ~sa_r[2];
          up   = ~b;
        end
        `HWPF_QD_X2:
        begin
          step = ea;
          up   = a ^ b;
        end
        default:
        begin
          step = ea | eb;
          up   = ea ? (a ^ b) : ~(a ^ b);
        end
      endcase
    end
    else if (decode_sel == `HWPF_DEC_HALL_F || decode_sel == `HWPF_DEC_HALL_R)
    begin
      step = (hi != 3'h7) & (hp != 3'h7) & (hi != hp);
      up   = (hi == ((hp == 3'h5) ? 3'h0 : hp + 3'h1));
    end
    up = up ^ rev;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sa_r    <= 3'h0;
      sb_r    <= 3'h0;
      sc_r    <= 3'h0;
      count_r <= 24'h000000;
      cap_r   <= 24'h000000;
      timer_r <= 24'h000000;
      acc_r   <= 16'h0000;
      wcnt_r  <= 8'h00;
      ramp_r  <= 15'h0000;
      pul_r   <= 1'b0;
      dir_r   <= 1'b0;
    end
    else
    begin
      sa_r <= {sa_r[1:0], pin_a};
      sb_r <= {sb_r[1:0], pin_b};
      sc_r <= {sc_r[1:0], pin_c};
      if (timer_mode)
      begin
        timer_r <= fire ? 24'h000000 : timer_r + 24'h000001;
        if (a & ~sa_r[2])
          count_r <= timer_r;
      end
      else if (step)
        count_r <= up ? count_r + 24'h000001 : count_r - 24'h000001;
      if (capture)
        cap_r <= count_r;
      if (pfm_tick)
      begin
        acc_r  <= fire ? rem[15:0] : sum[15:0];
        ramp_r <= ramp_r + 15'h0001;
        if (fire)
          wcnt_r <= (pulse_width == 8'h00) ? 8'h01 : pulse_width;
        else if (wcnt_r != 8'h00)
          wcnt_r <= wcnt_r - 8'h01;
      end
      pul_r <= c_is_pfm ? (wcnt_r != 8'h00) : ({1'b0, ramp_r} < mag);
      dir_r <= pfm_cmd[15];
    end
  end
endmodule // hwpf_chan

/* File: hwpf_checker.sv */
// Checker for hwpf_top: bus handshakes, read map and pin outputs
// Assumes it is bound into hwpf_top with one clock domain
`timescale 1ns/10ps
`include "hwpf_map.vh"
module hwpf_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [1:0]  pul_out,
  input wire [1:0]  dir_out
);
  reg  [5:0] ar_idx_r;
  wire       ar_go = s_axi_arvalid && s_axi_arready;
  wire       wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire       cnt_rd = ar_idx_r == `HWPF_IDX_CNT1 || ar_idx_r == `HWPF_IDX_CNT2;
  // Index of the read in flight
  always @(posedge aclk)
    if (ar_go)
      ar_idx_r <= s_axi_araddr[7:2];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_out;
    $rose(aresetn) |-> pul_out == 2'b00 && dir_out == 2'b00 && !s_axi_rvalid;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not cleared");
  property p_b_drop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
  property p_r_drop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read answer repeated");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken early");
  property p_w_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken early");
  property p_rd_lat;
    ar_go |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_wr_lat;
    wr_go |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_unmap;
    s_axi_rvalid && ar_idx_r > `HWPF_IDX_CAPT |-> s_axi_rresp == `HWPF_RESP_SLV
      && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_cnt24;
    s_axi_rvalid && cnt_rd |-> s_axi_rresp == `HWPF_RESP_OKAY && s_axi_rdata[31:24] == 8'h00;
  endproperty
  a_cnt24: assert property (p_cnt24) else $error("counter wider than 24 bits");
  c_wr: cover property (wr_go);
  c_slv: cover property (s_axi_rvalid && s_axi_rresp == `HWPF_RESP_SLV);
  c_neg: cover property ($rose(pul_out[1]) && dir_out[1]);
endmodule // hwpf_checker
bind hwpf_top hwpf_checker i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pul_out,
  .dir_out);

/* File: hwpf_enc.sv */
// Encoder emulator for one channel, quadrature or six-state Hall
// Assumes the bench raises step for one clock per position change
`timescale 1ns/10ps
module hwpf_enc (
  input  wire aclk,
  input  wire step,
  input  wire up,
  input  wire hall,
  output wire a,
  output wire b,
  output wire c
);
  integer     pos = 0;
  wire [7:0]  quad = 8'h78 >> (2 * (pos % 4));
  wire [17:0] hs = 18'h2cc99 >> (3 * (pos % 6));
  // Twelve-state ring serves both formats
  always @(posedge aclk)
    if (step)
      pos <= (pos + (up ? 1 : 11)) % 12;
  assign {a, b, c} = hall ? hs[2:0] : {quad[1:0], 1'b0};
endmodule // hwpf_enc

/* File: hwpf_map.vh */
// Register indices, field layout and codes for the handwheel encoder/PFM block
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite bus
`ifndef HWPF_MAP_VH
`define HWPF_MAP_VH
`define HWPF_IDX_CAP1   6'h03
`define HWPF_IDX_CMD1   6'h04
`define HWPF_IDX_CNT1   6'h11
`define HWPF_IDX_CMD2   6'h12
`define HWPF_IDX_CNT2   6'h19
`define HWPF_IDX_CAP2   6'h1b
`define HWPF_IDX_DEC1   6'h20
`define HWPF_IDX_DEC2   6'h21
`define HWPF_IDX_MODE1  6'h22
`define HWPF_IDX_MODE2  6'h23
`define HWPF_IDX_PFMCLK 6'h24
`define HWPF_IDX_PWID   6'h25
`define HWPF_IDX_CAPT   6'h26
`define HWPF_CMD_LSB    8
`define HWPF_CMD_MSB    23
`define HWPF_CNT_W      24
`define HWPF_MODE_PFM   1
`define HWPF_DEC_REV    2
`define HWPF_DEC_HALL_F 4'hb
`define HWPF_DEC_TIMER  4'hc
`define HWPF_DEC_HALL_R 4'hf
`define HWPF_QD_PD      2'h0
`define HWPF_QD_X1      2'h1
`define HWPF_QD_X2      2'h2
`define HWPF_QD_X4      2'h3
`define HWPF_CMD_FULL   16'h7fff
`define HWPF_PFM_MOD    17'h0fffe
`define HWPF_RST_CMD    24'h000000
`define HWPF_RST_DEC    4'h0
`define HWPF_RST_MODE   2'h0
`define HWPF_RST_PFMCLK 16'h0000
`define HWPF_RST_PWID   8'h01
`define HWPF_RESP_OKAY  2'h0
`define HWPF_RESP_SLV   2'h2
`endif

/* File: hwpf_top.v */
// Handwheel port block: two encoder counters and two PFM outputs, AXI4-Lite
// Assumes one 40 MHz clock; handwheel pins are asynchronous to it
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "hwpf_map.vh"
// Contract
// - Codes 0-3 pulse/dir, x1, x2, x4 forward; 4-7 same, reversed sense.
// - Code 11 counts six-state Hall forward, code 15 reverse.
// - Code 12: internal pulse clears timer, external pulse latches it.
// - Quadrature inputs accepted; no index input on either channel.
// - Two independent encoder channels and two independent PFM outputs.
// - Channel 1 counter at index 0x11, channel 2 at index 0x19.
// - Each counter reads as 24 bits from bit 0.
// - Captured counts sit as 24 bits at index 0x03 (channel 1) and 0x1b (channel 2).
// - Output mode codes 0-3; C output is PFM for codes 2 and 3.
// - Signed 16-bit command at bits 23:8 of index 0x04 and 0x12.
// - Command 32767 gives half the PFM clock; smaller scale proportionally.
// - One pulse width setting shared by both channels.
module hwpf_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [1:0]  hw_a,
  input  wire [1:0]  hw_b,
  input  wire [1:0]  hw_c,
  output wire [1:0]  pul_out,
  output wire [1:0]  dir_out
);
  reg  [5:0]  aw_idx_r;
  reg         aw_got_r;
  reg  [31:0] wdata_r;
  reg  [3:0]  wstrb_r;
  reg         w_got_r;
  reg  [47:0] cmd_r;
  reg  [7:0]  dec_r;
  reg  [3:0]  mode_r;
  reg  [15:0] pfmclk_r;
  reg  [7:0]  pwid_r;
  reg  [1:0]  capt_r;
  reg  [15:0] div_r;
  reg         tick_r;
  reg  [31:0] rd_val;
  reg         rd_ok;
  reg         wr_ok;
  wire [47:0] cnt_w;
  wire [47:0] cap_w;
  wire [31:0] wmask;
  wire [31:0] wmerge_cmd1;
  wire [31:0] wmerge_cmd2;
  wire [31:0] wmerge_clk;
  wire        do_wr;
  wire [5:0]  ar_idx;

  assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr         = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign ar_idx        = s_axi_araddr[7:2];
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  assign wmerge_cmd1 = (wdata_r & wmask) | ({8'h00, cmd_r[23:0]} & ~wmask);
  assign wmerge_cmd2 = (wdata_r & wmask) | ({8'h00, cmd_r[47:24]} & ~wmask);
  assign wmerge_clk  = (wdata_r & wmask) | ({16'h0000, pfmclk_r} & ~wmask);

  // Write address decode
  always @*
  begin
    case (aw_idx_r)
      `HWPF_IDX_CMD1, `HWPF_IDX_CMD2, `HWPF_IDX_DEC1, `HWPF_IDX_DEC2,
      `HWPF_IDX_MODE1, `HWPF_IDX_MODE2, `HWPF_IDX_PFMCLK, `HWPF_IDX_PWID,
      `HWPF_IDX_CAPT, `HWPF_IDX_CAP1, `HWPF_IDX_CAP2, `HWPF_IDX_CNT1,
      `HWPF_IDX_CNT2:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // Read data mux
  always @*
  begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (ar_idx)
      `HWPF_IDX_CAP1:   rd_val = {8'h00, cap_w[23:0]};
      `HWPF_IDX_CAP2:   rd_val = {8'h00, cap_w[47:24]};
      `HWPF_IDX_CMD1:   rd_val = {8'h00, cmd_r[23:0]};
      `HWPF_IDX_CMD2:   rd_val = {8'h00, cmd_r[47:24]};
      `HWPF_IDX_CNT1:   rd_val = {8'h00, cnt_w[23:0]};
      `HWPF_IDX_CNT2:   rd_val = {8'h00, cnt_w[47:24]};
      `HWPF_IDX_DEC1:   rd_val = {28'h0000000, dec_r[3:0]};
      `HWPF_IDX_DEC2:   rd_val = {28'h0000000, dec_r[7:4]};
      `HWPF_IDX_MODE1:  rd_val = {30'h0000000, mode_r[1:0]};
      `HWPF_IDX_MODE2:  rd_val = {30'h0000000, mode_r[3:2]};
      `HWPF_IDX_PFMCLK: rd_val = {16'h0000, pfmclk_r};
      `HWPF_IDX_PWID:   rd_val = {24'h000000, pwid_r};
      `HWPF_IDX_CAPT:   rd_val = 32'h00000000;
      default:          rd_ok  = 1'b0;
    endcase
  end

  // Write channel handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_idx_r     <= 6'h00;
      aw_got_r     <= 1'b0;
      wdata_r      <= 32'h00000000;
      wstrb_r      <= 4'h0;
      w_got_r      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `HWPF_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_idx_r <= s_axi_awaddr[7:2];
        aw_got_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_got_r <= 1'b1;
      end
      if (do_wr)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `HWPF_RESP_OKAY : `HWPF_RESP_SLV;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel handshake
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `HWPF_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `HWPF_RESP_OKAY : `HWPF_RESP_SLV;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Control registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_r    <= {`HWPF_RST_CMD, `HWPF_RST_CMD};
      dec_r    <= {`HWPF_RST_DEC, `HWPF_RST_DEC};
      mode_r   <= {`HWPF_RST_MODE, `HWPF_RST_MODE};
      pfmclk_r <= `HWPF_RST_PFMCLK;
      pwid_r   <= `HWPF_RST_PWID;
      capt_r   <= 2'h0;
    end
    else
    begin
      capt_r <= 2'h0;
      if (do_wr)
      begin
        case (aw_idx_r)
          `HWPF_IDX_CMD1:
            cmd_r[23:0] <= wmerge_cmd1[23:0];
          `HWPF_IDX_CMD2:
            cmd_r[47:24] <= wmerge_cmd2[23:0];
          `HWPF_IDX_DEC1:
            if (wstrb_r[0])
              dec_r[3:0] <= wdata_r[3:0];
          `HWPF_IDX_DEC2:
            if (wstrb_r[0])
              dec_r[7:4] <= wdata_r[3:0];
          `HWPF_IDX_MODE1:
            if (wstrb_r[0])
              mode_r[1:0] <= wdata_r[1:0];
          `HWPF_IDX_MODE2:
            if (wstrb_r[0])
              mode_r[3:2] <= wdata_r[1:0];
          `HWPF_IDX_PFMCLK:
            pfmclk_r <= wmerge_clk[15:0];
          `HWPF_IDX_PWID:
            if (wstrb_r[0])
              pwid_r <= wdata_r[7:0];
          `HWPF_IDX_CAPT:
            if (wstrb_r[0])
              capt_r <= wdata_r[1:0];
          default:
            capt_r <= 2'h0;
        endcase
      end
    end
  end

  // PFM clock divider: one tick every pfmclk_r+1 cycles
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end
    else if (div_r >= pfmclk_r)
    begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1;
    end
    else
    begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Two independent channels
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_ch
      hwpf_chan u_chan (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .pin_a       (hw_a[gi]),
        .pin_b       (hw_b[gi]),
        .pin_c       (hw_c[gi]),
        .decode_sel  (dec_r[gi*4+3:gi*4]),
        .pfm_cmd     (cmd_r[gi*24+`HWPF_CMD_MSB:gi*24+`HWPF_CMD_LSB]),
        .c_is_pfm    (mode_r[gi*2+`HWPF_MODE_PFM]),
        .pfm_tick    (tick_r),
        .pulse_width (pwid_r),
        .capture     (capt_r[gi]),
        .count_r     (cnt_w[gi*24+23:gi*24]),
        .cap_r       (cap_w[gi*24+23:gi*24]),
        .pul_r       (pul_out[gi]),
        .dir_r       (dir_out[gi])
      );
    end
  endgenerate
endmodule // hwpf_top

/* File: hwpf_top_tb.sv */
// Self-checking bench for hwpf_top: bus, decode modes, capture, PFM
// Assumes hwpf_checker is bound in and hwpf_enc stands for both encoders
`timescale 1ns/10ps
`include "hwpf_map.vh"
module hwpf_top_tb;
  localparam [1:0] ok = `HWPF_RESP_OKAY;
  localparam [1:0] slv = `HWPF_RESP_SLV;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  awaddr = 8'h00;
  reg  [7:0]  araddr = 8'h00;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  reg  [1:0]  st = 2'b00;
  reg         up1 = 1'b1;
  reg         hall1 = 1'b0;
  reg  [1:0]  pul_q = 2'b00;
  reg  [31:0] d;
  reg  [31:0] d2;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp, pul, dir, ha, hb, hc;
  wire [31:0] rdata;
  integer     bad_count = 0, checks_done = 0, cyc = 0, seed = 40415;
  integer     m1 = 0, m2 = 0, e1 = 0, e2 = 0, i, x, y;
  integer     codes [15] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 13, 14, 8, 11, 15};
  integer     mult [15] = '{2, 2, 4, 8, -2, -2, -4, -8, 0, 0, 0, 0, 0, 8, -8};

  hwpf_top i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .hw_a(ha),
    .hw_b(hb), .hw_c(hc), .pul_out(pul), .dir_out(dir)
  );
  hwpf_enc i_enc1 (.aclk(aclk), .step(st[0]), .up(up1), .hall(hall1), .a(ha[0]), .b(hb[0]),
    .c(hc[0]));
  hwpf_enc i_enc2 (.aclk(aclk), .step(st[1]), .up(1'b1), .hall(1'b0), .a(ha[1]), .b(hb[1]),
    .c(hc[1]));

  always #12.5 aclk = ~aclk;

  // Pulse edge counts and run ceiling
  always @(posedge aclk)
  begin
    pul_q <= pul;
    e1 <= e1 + (aresetn & pul[0] & ~pul_q[0]);
    e2 <= e2 + (aresetn & pul[1] & ~pul_q[1]);
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count = bad_count + 1;
      close_out;
    end
  end

  function integer near(input integer s, input integer t);
    near = (s >= t - 1 && s <= t + 1) ? t : s;
  endfunction

  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task wr(input [5:0] idx, input [31:0] v, input [1:0] er);
  begin
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
  end
  endtask

  task rd(input [5:0] idx, output [31:0] v, input [1:0] er);
  begin
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    rready <= 1'b0;
    chk(rresp, er);
  end
  endtask

  task move(input integer n, input dir1, input both, input integer gap);
    integer k;
  begin
    for (k = 0; k < n; k = k + 1)
    begin
      @(posedge aclk);
      up1 <= dir1;
      st <= {both, 1'b1};
      @(posedge aclk);
      st <= 2'b00;
      repeat (gap) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
  end
  endtask

  task close_out;
  begin
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`HWPF_IDX_CMD1, d, ok);
    chk(d, 32'h0);
    rd(6'h3f, d, slv);
    chk(d, 32'h0);
    wr(6'h30, 32'h1, slv);
    d = $random(seed);
    wr(`HWPF_IDX_CMD1, d, ok);
    rd(`HWPF_IDX_CMD1, d2, ok);
    chk(d2, d & 32'h00ffffff);
    wr(`HWPF_IDX_CNT1, $random(seed), ok);
    wr(`HWPF_IDX_DEC2, 32'h3, ok);
    // Every decode code except 12 against the running count
    for (i = 0; i < 15; i = i + 1)
    begin
      wr(`HWPF_IDX_DEC1, codes[i], ok);
      hall1 <= (i >= 12);
      move(16, 1'b1, 1'b1, 0);
      move(8, 1'b0, 1'b0, 3);
      m1 = m1 + mult[i];
      m2 = m2 + 16;
      rd(`HWPF_IDX_CNT1, d, ok);
      chk(d, m1 & 32'h00ffffff);
      rd(`HWPF_IDX_CNT2, d, ok);
      chk(d, m2 & 32'h00ffffff);
    end
    move(12, 1'b0, 1'b0, 0);
    m1 = m1 + 12;
    rd(`HWPF_IDX_CNT1, d, ok);
    chk(d, m1 & 32'h00ffffff);
    wr(`HWPF_IDX_CAPT, 32'h3, ok);
    repeat (4) @(posedge aclk);
    rd(`HWPF_IDX_CAP1, d, ok);
    chk(d, m1 & 32'h00ffffff);
    rd(`HWPF_IDX_CAP2, d, ok);
    chk(d, m2 & 32'h00ffffff);
    // PFM rate, sign and output mode
    wr(`HWPF_IDX_PFMCLK, 32'h3, ok);
    wr(`HWPF_IDX_CMD2, 32'h00c00100, ok);
    wr(`HWPF_IDX_MODE2, 32'h2, ok);
    wr(`HWPF_IDX_CMD1, 32'h007fff00, ok);
    y = 100 * 16383 / 65534;
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`HWPF_IDX_MODE1, i, ok);
      x = (i > 1) ? 100 / 2 : 0;
      repeat (20) @(posedge aclk);
      d = e1;
      d2 = e2;
      repeat (400) @(posedge aclk);
      chk(near(e1 - d, x), x);
      chk(near(e2 - d2, y), y);
      chk(dir, 2'b10);
    end
    // Width of two ticks keeps the half-rate channel high
    wr(`HWPF_IDX_PWID, 32'h2, ok);
    rd(`HWPF_IDX_PWID, d, ok);
    chk(d, 32'h2);
    repeat (20) @(posedge aclk);
    d = e1;
    d2 = e2;
    repeat (400) @(posedge aclk);
    chk(near(e1 - d, 0), 0);
    chk(near(e2 - d2, y), y);
    wr(`HWPF_IDX_DEC1, 32'hc, ok);
    move(4, 1'b1, 1'b0, 0);
    rd(`HWPF_IDX_CNT1, d, ok);
    chk((d < 8) ? 32'h0 : d, 32'h0);
    close_out;
  end
endmodule // hwpf_top_tb
